// File: lsm_defs.svh
/*
  register offsets, field positions, reset values and counts
  for the scrambler status and management channel registers.
  assumes inclusion by lsm_regs only.
*/
`ifndef LSM_DEFS_SVH
`define LSM_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define LSM_OFF_RX_SCR    8'h18
`define LSM_OFF_CM_CFG    8'h1C
`define LSM_OFF_CM_STAT   8'h20
`define LSM_OFF_IRQ_STAT  8'h28
`define LSM_OFF_IRQ_MASK  8'h2C

// ****************************************
// field positions
// ****************************************
`define LSM_SCR_ACTIVE    31
`define LSM_CFG_HDLC_AUTO 12
`define LSM_CFG_HDLC_FILT 11
`define LSM_CFG_HDLC_LSB  8
`define LSM_CFG_ETH_AUTO  7
`define LSM_CFG_ETH_FILT  6
`define LSM_STAT_HDLC_VAL 11
`define LSM_STAT_ETH_VAL  6
`define LSM_IRQ_SCR       0
`define LSM_IRQ_HDLC      1
`define LSM_IRQ_ETH       2

// ****************************************
// reset values and encodings
// ****************************************
`define LSM_RST_HDLC_TX   3'h6
`define LSM_RST_ETH_TX    6'h14
`define LSM_ETH_PTR_MIN   6'h14
`define LSM_ETH_PTR_MAX   6'h3F
`define LSM_PV_PLAIN      8'h01
`define LSM_PV_SCRAMBLED  8'h02

// ****************************************
// timing counts
// ****************************************
`define LSM_FILTER_HF     5

`endif

// File: lsm_pkg.sv
/*
  types shared by the management channel register block.
  assumes nothing of its surroundings.
*/
package lsm_pkg;
  typedef enum logic [2:0] {
    LSM_F_IDLE  = 3'b001,
    LSM_F_TRACK = 3'b010,
    LSM_F_LOCK  = 3'b100
  } lsm_filt_state_t;
endpackage : lsm_pkg

// File: lsm_value_filter.sv
/*
  consecutive-hyperframe filter for one received control field.
  assumes one sample strobe per hyperframe, same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lsm_value_filter import lsm_pkg::*; #(
  parameter int W     = 3,
  parameter int DEPTH = 5
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  // sample side
  input  wire logic         sample_i,
  input  wire logic [W-1:0] value_i,
  input  wire logic         in_range_i,
  input  wire logic         filter_en_i,
  // accepted side
  output logic              acc_valid_o,
  output logic [W-1:0]      acc_value_o,
  output logic              acc_new_o
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  lsm_filt_state_t state, next_state;
  logic [W-1:0]    last, next_last;
  logic [CW-1:0]   cnt, next_cnt;
  logic            next_valid, next_new;
  logic [W-1:0]    next_value;

  always_comb begin
    next_state = state;
    next_last  = last;
    next_cnt   = cnt;
    next_valid = acc_valid_o;
    next_value = acc_value_o;
    next_new   = 1'b0;
    if (sample_i) begin
      if (!in_range_i) begin
        next_state = LSM_F_IDLE;
        next_cnt   = '0;
      end else begin
        unique case (state)
          LSM_F_IDLE: begin
            next_state = LSM_F_TRACK;
            next_last  = value_i;
            next_cnt   = CW'(1);
          end
          LSM_F_TRACK, LSM_F_LOCK: begin
            if (value_i != last) begin
              next_state = LSM_F_TRACK;
              next_last  = value_i;
              next_cnt   = CW'(1);
            end else if (cnt != FULL) begin
              next_cnt = cnt + CW'(1);
            end
          end
        endcase
        if (!filter_en_i || next_cnt == FULL) begin
          next_state = LSM_F_LOCK;
          if (!acc_valid_o || acc_value_o != value_i) begin
            next_valid = 1'b1;
            next_value = value_i;
            next_new   = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state       <= LSM_F_IDLE;
      last        <= '0;
      cnt         <= '0;
      acc_valid_o <= 1'b0;
      acc_value_o <= '0;
      acc_new_o   <= 1'b0;
    end else begin
      state       <= next_state;
      last        <= next_last;
      cnt         <= next_cnt;
      acc_valid_o <= next_valid;
      acc_value_o <= next_value;
      acc_new_o   <= next_new;
    end
  end

  filt_depth_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    acc_new_o && $past(filter_en_i) |-> cnt == FULL)
    else $error("filtered value accepted before full run");
endmodule : lsm_value_filter
`default_nettype wire

// File: lsm_descrambler.sv
/*
  parallel descrambler, 31-bit lfsr 1 + x^28 + x^31.
  assumes load at each hyperframe start, same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lsm_descrambler #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  // control
  input  wire logic         load_i,
  input  wire logic [30:0]  seed_i,
  input  wire logic         enable_i,
  // data
  input  wire logic         valid_i,
  input  wire logic [W-1:0] data_i,
  output logic              valid_o,
  output logic [W-1:0]      data_o
);
  logic [30:0]  lfsr, next_lfsr;
  logic [W-1:0] ks, next_data;
  logic [30:0]  s;

  // one feedback step per data bit, msb first
  always_comb begin
    s = load_i ? seed_i : lfsr;
    ks = '0;
    for (int i = W - 1; i >= 0; i--) begin
      ks[i] = s[30] ^ s[27];
      s     = {s[29:0], ks[i]};
    end
    next_lfsr = lfsr;
    if (load_i) begin
      next_lfsr = seed_i;
    end
    if (valid_i) begin
      next_lfsr = s;
    end
    next_data = enable_i ? (data_i ^ ks) : data_i;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfsr    <= '0;
      valid_o <= 1'b0;
      data_o  <= '0;
    end else begin
      lfsr    <= next_lfsr;
      valid_o <= valid_i;
      data_o  <= next_data;
    end
  end
endmodule : lsm_descrambler
`default_nettype wire

// File: lsm_regs.sv
/*
  receive scrambler status and management channel registers,
  with received-value filters, descrambler and interrupt.
  assumes link receive inputs on clock_i, one hf start pulse
  per hyperframe carrying that hyperframe's control bytes.
*/
// The plain strobed port is this design's own decision.
// Contract
// - bit 31 shows incoming scrambling, reset 0
// - scrambling decided by received protocol version
// - received seed read-only, used to descramble
// - hdlc rate autoneg enable, reset 1
// - no negotiation support: autoneg bits read 0
// - hdlc rate filter enable, writable, reset 1
// - hdlc transmit rate 110 into Z.66.0
// - ethernet pointer autoneg enable, reset 1
// - ethernet pointer filter enable, writable, reset 1
// - ethernet transmit pointer 20 into Z.194.0
// - hdlc accepted valid flag, reset 0
// - accepted hdlc rate from Z.66.0
// - ethernet accepted valid flag, reset 0
// - ethernet pointer valid only 0x14 to 0x3F
// - version 1 plain, 2 scrambled
`include "lsm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module lsm_regs import lsm_pkg::*; #(
  parameter bit AUTONEG_SUPPORT = 1'b1,
  parameter int DATA_W          = 32,
  parameter int FILTER_HF       = `LSM_FILTER_HF
) (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              arst_n_i,
  // register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  // link receive side
  input  wire logic              rx_hf_start_i,
  input  wire logic [7:0]        rx_prot_ver_i,
  input  wire logic              rx_prot_ver_valid_i,
  input  wire logic [30:0]       rx_seed_i,
  input  wire logic              rx_seed_valid_i,
  input  wire logic [7:0]        rx_hdlc_byte_i,
  input  wire logic [7:0]        rx_eth_byte_i,
  input  wire logic              rx_data_valid_i,
  input  wire logic [DATA_W-1:0] rx_data_i,
  // descrambled data
  output logic                   rx_descr_valid_o,
  output logic [DATA_W-1:0]      rx_descr_data_o,
  // link transmit control bytes
  output logic [7:0]             tx_hdlc_byte_o,
  output logic [7:0]             tx_eth_byte_o,
  // interrupt
  output logic                   irq_o
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta, rst_n;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // state
  // ****************************************
  logic        scr_active, next_scr_active;
  logic [30:0] scr_seed, next_scr_seed;
  logic        hdlc_rate_autoneg_en, next_hdlc_auto;
  logic        hdlc_rate_filter_en, next_hdlc_filt;
  logic [2:0]  hdlc_rate_transmit, next_hdlc_tx;
  logic        eth_pointer_autoneg_en, next_eth_auto;
  logic        eth_pointer_filter_en, next_eth_filt;
  logic [5:0]  eth_pointer_transmit, next_eth_tx;
  logic [2:0]  irq_status, next_irq_status;
  logic [2:0]  irq_mask, next_irq_mask;
  logic [31:0] next_rdata;
  logic        next_irq;
  logic [7:0]  next_tx_hdlc, next_tx_eth;

  logic        hdlc_rate_accepted_valid;
  logic [2:0]  hdlc_rate_accepted;
  logic        hdlc_new;
  logic        eth_pointer_accepted_valid;
  logic [5:0]  eth_pointer_accepted;
  logic        eth_new;
  logic        eth_in_range;
  logic        cfg_wr;

  assign eth_in_range = (rx_eth_byte_i[5:0] >= `LSM_ETH_PTR_MIN) &&
                        (rx_eth_byte_i[7:6] == 2'h0);
  assign cfg_wr = reg_wr_i && (reg_addr_i == `LSM_OFF_CM_CFG);

  // ****************************************
  // received value filters
  // ****************************************
  lsm_value_filter #(
    .W     (3),
    .DEPTH (FILTER_HF)
  ) u_hdlc_filter (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n),
    .sample_i    (rx_hf_start_i),
    .value_i     (rx_hdlc_byte_i[2:0]),
    .in_range_i  (rx_hdlc_byte_i[7:3] == 5'h00),
    .filter_en_i (hdlc_rate_filter_en),
    .acc_valid_o (hdlc_rate_accepted_valid),
    .acc_value_o (hdlc_rate_accepted),
    .acc_new_o   (hdlc_new)
  );

  lsm_value_filter #(
    .W     (6),
    .DEPTH (FILTER_HF)
  ) u_eth_filter (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n),
    .sample_i    (rx_hf_start_i),
    .value_i     (rx_eth_byte_i[5:0]),
    .in_range_i  (eth_in_range),
    .filter_en_i (eth_pointer_filter_en),
    .acc_valid_o (eth_pointer_accepted_valid),
    .acc_value_o (eth_pointer_accepted),
    .acc_new_o   (eth_new)
  );

  // ****************************************
  // descrambler
  // ****************************************
  // incoming data descrambled with received seed
  lsm_descrambler #(
    .W (DATA_W)
  ) u_descr (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n),
    .load_i   (rx_hf_start_i),
    .seed_i   (rx_seed_valid_i ? rx_seed_i : scr_seed),
    .enable_i (scr_active),
    .valid_i  (rx_data_valid_i),
    .data_i   (rx_data_i),
    .valid_o  (rx_descr_valid_o),
    .data_o   (rx_descr_data_o)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_scr_active = scr_active;
    next_scr_seed   = scr_seed;
    if (rx_prot_ver_valid_i && rx_prot_ver_i == `LSM_PV_SCRAMBLED) begin
      next_scr_active = 1'b1;
    end else if (rx_prot_ver_valid_i && rx_prot_ver_i == `LSM_PV_PLAIN) begin
      next_scr_active = 1'b0;
    end
    if (rx_seed_valid_i) begin
      next_scr_seed = rx_seed_i;
    end

    next_hdlc_auto = hdlc_rate_autoneg_en;
    next_hdlc_filt = hdlc_rate_filter_en;
    next_hdlc_tx   = hdlc_rate_transmit;
    next_eth_auto  = eth_pointer_autoneg_en;
    next_eth_filt  = eth_pointer_filter_en;
    next_eth_tx    = eth_pointer_transmit;
    next_irq_mask  = irq_mask;
    if (cfg_wr) begin
      next_hdlc_auto = AUTONEG_SUPPORT & reg_wdata_i[`LSM_CFG_HDLC_AUTO];
      next_eth_auto  = AUTONEG_SUPPORT & reg_wdata_i[`LSM_CFG_ETH_AUTO];
      next_hdlc_filt = reg_wdata_i[`LSM_CFG_HDLC_FILT];
      next_eth_filt  = reg_wdata_i[`LSM_CFG_ETH_FILT];
      next_hdlc_tx   = reg_wdata_i[`LSM_CFG_HDLC_LSB +: 3];
      next_eth_tx    = reg_wdata_i[5:0];
    end
    // negotiated value overrides a same-cycle software write
    if (hdlc_new && hdlc_rate_autoneg_en) begin
      next_hdlc_tx = hdlc_rate_accepted;
    end
    if (eth_new && eth_pointer_autoneg_en) begin
      next_eth_tx = eth_pointer_accepted;
    end
    if (reg_wr_i && reg_addr_i == `LSM_OFF_IRQ_MASK) begin
      next_irq_mask = reg_wdata_i[2:0];
    end

    // write one clears, a new event wins over the clear
    next_irq_status = irq_status;
    if (reg_wr_i && reg_addr_i == `LSM_OFF_IRQ_STAT) begin
      next_irq_status = irq_status & ~reg_wdata_i[2:0];
    end
    next_irq_status[`LSM_IRQ_SCR]  = next_irq_status[`LSM_IRQ_SCR] |
                                     (next_scr_active != scr_active);
    next_irq_status[`LSM_IRQ_HDLC] = next_irq_status[`LSM_IRQ_HDLC] | hdlc_new;
    next_irq_status[`LSM_IRQ_ETH]  = next_irq_status[`LSM_IRQ_ETH] | eth_new;
    next_irq = |(next_irq_status & next_irq_mask);

    next_tx_hdlc = {5'h00, next_hdlc_tx};
    next_tx_eth  = {2'h0, next_eth_tx};

    next_rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `LSM_OFF_RX_SCR:   next_rdata = {scr_active, scr_seed};
        `LSM_OFF_CM_CFG:   next_rdata = {19'h0, hdlc_rate_autoneg_en,
                                         hdlc_rate_filter_en, hdlc_rate_transmit,
                                         eth_pointer_autoneg_en,
                                         eth_pointer_filter_en, eth_pointer_transmit};
        `LSM_OFF_CM_STAT:  next_rdata = {20'h0, hdlc_rate_accepted_valid,
                                         hdlc_rate_accepted, 1'b0,
                                         eth_pointer_accepted_valid,
                                         eth_pointer_accepted};
        `LSM_OFF_IRQ_STAT: next_rdata = {29'h0, irq_status};
        `LSM_OFF_IRQ_MASK: next_rdata = {29'h0, irq_mask};
        default:           next_rdata = '0;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      scr_active             <= 1'b0;
      scr_seed               <= '0;
      hdlc_rate_autoneg_en   <= AUTONEG_SUPPORT;
      hdlc_rate_filter_en    <= 1'b1;
      hdlc_rate_transmit     <= `LSM_RST_HDLC_TX;
      eth_pointer_autoneg_en <= AUTONEG_SUPPORT;
      eth_pointer_filter_en  <= 1'b1;
      eth_pointer_transmit   <= `LSM_RST_ETH_TX;
      irq_status             <= '0;
      irq_mask               <= '0;
      reg_rdata_o            <= '0;
      irq_o                  <= 1'b0;
      tx_hdlc_byte_o         <= {5'h00, `LSM_RST_HDLC_TX};
      tx_eth_byte_o          <= {2'h0, `LSM_RST_ETH_TX};
    end else begin
      scr_active             <= next_scr_active;
      scr_seed               <= next_scr_seed;
      hdlc_rate_autoneg_en   <= next_hdlc_auto;
      hdlc_rate_filter_en    <= next_hdlc_filt;
      hdlc_rate_transmit     <= next_hdlc_tx;
      eth_pointer_autoneg_en <= next_eth_auto;
      eth_pointer_filter_en  <= next_eth_filt;
      eth_pointer_transmit   <= next_eth_tx;
      irq_status             <= next_irq_status;
      irq_mask               <= next_irq_mask;
      reg_rdata_o            <= next_rdata;
      irq_o                  <= next_irq;
      tx_hdlc_byte_o         <= next_tx_hdlc;
      tx_eth_byte_o          <= next_tx_eth;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence cfg_write_s;
    reg_wr_i && reg_addr_i == `LSM_OFF_CM_CFG;
  endsequence

  sequence scr_read_s;
    reg_rd_i && reg_addr_i == `LSM_OFF_RX_SCR;
  endsequence

  scr_from_version_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    rx_prot_ver_valid_i && rx_prot_ver_i == `LSM_PV_SCRAMBLED |=> scr_active)
    else $error("version 2 did not set scrambling");

  plain_version_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    rx_prot_ver_valid_i && rx_prot_ver_i == `LSM_PV_PLAIN |=> !scr_active)
    else $error("version 1 did not clear scrambling");

  scr_read_bit_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    scr_read_s |=> reg_rdata_o == {$past(scr_active), $past(scr_seed)})
    else $error("scrambler status read wrong");

  seed_capture_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    rx_seed_valid_i ##1 !rx_seed_valid_i ##1 scr_read_s |=>
      reg_rdata_o[30:0] == $past(rx_seed_i, 3))
    else $error("received seed not reported");

  autoneg_ro_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    !AUTONEG_SUPPORT |-> !hdlc_rate_autoneg_en && !eth_pointer_autoneg_en)
    else $error("autoneg bit set without support");

  filter_write_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    cfg_write_s |=> hdlc_rate_filter_en == $past(reg_wdata_i[`LSM_CFG_HDLC_FILT]) &&
                    eth_pointer_filter_en == $past(reg_wdata_i[`LSM_CFG_ETH_FILT]))
    else $error("filter enable write lost");

  tx_bytes_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    ##1 tx_hdlc_byte_o == {5'h00, hdlc_rate_transmit} &&
        tx_eth_byte_o == {2'h0, eth_pointer_transmit})
    else $error("transmit control byte mismatch");

  eth_range_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    eth_pointer_accepted_valid |-> eth_pointer_accepted >= `LSM_ETH_PTR_MIN)
    else $error("accepted pointer below window");

  hdlc_valid_rise_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    $rose(hdlc_rate_accepted_valid) |-> hdlc_new)
    else $error("hdlc valid rose without accept");

  irq_level_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    ##1 irq_o == |(irq_status & irq_mask))
    else $error("interrupt level mismatch");
endmodule : lsm_regs
`default_nettype wire

// File: lsm_link_partner.sv
/*
  far-end link node model: sends one hyperframe's control bytes,
  protocol version, seed, and single data words toward the block.
  assumes the bench calls its tasks, all on clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
module lsm_link_partner (
  // clock
  input  wire logic   clock_i,
  // link toward the block
  output logic        hf_start_o,
  output logic [7:0]  prot_ver_o,
  output logic        prot_ver_valid_o,
  output logic [30:0] seed_o,
  output logic        seed_valid_o,
  output logic [7:0]  hdlc_byte_o,
  output logic [7:0]  eth_byte_o,
  output logic        data_valid_o,
  output logic [31:0] data_o
);
  // ****************************************
  // idle state
  // ****************************************
  initial begin
    hf_start_o = 1'b0;
    prot_ver_o = 8'h00;
    prot_ver_valid_o = 1'b0;
    seed_o = 31'h0;
    seed_valid_o = 1'b0;
    hdlc_byte_o = 8'h00;
    eth_byte_o = 8'h00;
    data_valid_o = 1'b0;
    data_o = 32'h0;
  end

  // ****************************************
  // hyperframe and data traffic
  // ****************************************
  // version 1 plain, 2 scrambled
  task automatic send_hf(input logic [7:0] ver, input logic [30:0] sd,
                         input logic [7:0] hb, input logic [7:0] eb);
    @(posedge clock_i);
    hf_start_o <= 1'b1;
    prot_ver_o <= ver;
    prot_ver_valid_o <= 1'b1;
    seed_o <= sd;
    seed_valid_o <= 1'b1;
    hdlc_byte_o <= hb;
    eth_byte_o <= eb;
    @(posedge clock_i);
    // lines not held after the strobe: show garbage, not the last value
    hf_start_o <= 1'b0;
    prot_ver_valid_o <= 1'b0;
    seed_valid_o <= 1'b0;
    prot_ver_o <= ~ver;
    seed_o <= ~sd;
    hdlc_byte_o <= ~hb;
    eth_byte_o <= ~eb;
  endtask : send_hf

  task automatic send_word(input logic [31:0] d);
    @(posedge clock_i);
    data_valid_o <= 1'b1;
    data_o <= d;
    @(posedge clock_i);
    data_valid_o <= 1'b0;
    data_o <= ~d;
  endtask : send_word
endmodule : lsm_link_partner
`default_nettype wire

// File: lsm_regs_tb_top.sv
/*
  self-checking bench for the management channel register block,
  plus a copy built without negotiation support.
  assumes lsm_pkg, lsm_regs and lsm_link_partner compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module lsm_regs_tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic        clock_i;
  logic        arst_n_i;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] rdata_a, rdata_b, data, descr_data, d, d2;
  logic        hf_start, ver_valid, seed_valid, data_valid, descr_valid, irq;
  logic [7:0]  prot_ver, hdlc_byte, eth_byte, tx_hdlc, tx_eth;
  logic [30:0] seed;
  int          error_cnt, samples_checked, cycle_cnt;

  // ****************************************
  // design and far end
  // ****************************************
  lsm_regs #(.AUTONEG_SUPPORT(1'b1), .FILTER_HF(2)) lsm_regs_i (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata_a),
    .rx_hf_start_i(hf_start), .rx_prot_ver_i(prot_ver), .rx_prot_ver_valid_i(ver_valid),
    .rx_seed_i(seed), .rx_seed_valid_i(seed_valid), .rx_hdlc_byte_i(hdlc_byte),
    .rx_eth_byte_i(eth_byte), .rx_data_valid_i(data_valid), .rx_data_i(data),
    .rx_descr_valid_o(descr_valid), .rx_descr_data_o(descr_data),
    .tx_hdlc_byte_o(tx_hdlc), .tx_eth_byte_o(tx_eth), .irq_o(irq));

  // no negotiation support: only config read-back is judged here
  lsm_regs #(.AUTONEG_SUPPORT(1'b0), .FILTER_HF(2)) lsm_regs_noneg_i (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata_b),
    .rx_hf_start_i(hf_start), .rx_prot_ver_i(prot_ver), .rx_prot_ver_valid_i(ver_valid),
    .rx_seed_i(seed), .rx_seed_valid_i(seed_valid), .rx_hdlc_byte_i(hdlc_byte),
    .rx_eth_byte_i(eth_byte), .rx_data_valid_i(data_valid), .rx_data_i(data),
    .rx_descr_valid_o(), .rx_descr_data_o(), .tx_hdlc_byte_o(), .tx_eth_byte_o(), .irq_o());

  lsm_link_partner lsm_link_partner_i (
    .clock_i(clock_i), .hf_start_o(hf_start), .prot_ver_o(prot_ver),
    .prot_ver_valid_o(ver_valid), .seed_o(seed), .seed_valid_o(seed_valid),
    .hdlc_byte_o(hdlc_byte), .eth_byte_o(eth_byte), .data_valid_o(data_valid),
    .data_o(data));

  // ****************************************
  // clock, timeout and shared tasks
  // ****************************************
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // whole run is under a hundred cycles
  always @(posedge clock_i) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock_i);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock_i);
    reg_rd <= 1'b0;
    #1;
    d = rdata_a;
    d2 = rdata_b;
  endtask : rd

  task automatic stop_test();
    $display("Summary: %0d mismatches in %0d comparisons", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    rd(8'h18); check(d, 32'h0);
    rd(8'h1C); check(d, 32'h0000_1ED4);
    check(d2, 32'h0000_0E54);
    rd(8'h20); check(d, 32'h0);
    check({24'h0, tx_hdlc}, 32'h06);
    check({24'h0, tx_eth}, 32'h14);
    check({31'h0, irq}, 32'h0);
  endtask : test_reset

  task automatic test_access();
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C); check(d, 32'h0000_1FFF);
    check(d2, 32'h0000_0F7F);
    check({24'h0, tx_hdlc}, 32'h07);
    check({24'h0, tx_eth}, 32'h3F);
    wr(8'h18, 32'hFFFF_FFFF);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h18); check(d, 32'h0);
    rd(8'h20); check(d, 32'h0);
    rd(8'h40); check(d, 32'h0);
  endtask : test_access

  task automatic test_filter();
    wr(8'h1C, 32'h0000_1ED4);
    lsm_link_partner_i.send_hf(8'h01, 31'h0, 8'h03, 8'h30);
    lsm_link_partner_i.send_hf(8'h01, 31'h0, 8'h03, 8'h20);
    rd(8'h20); check(d, 32'h0000_0B00);
    check({24'h0, tx_hdlc}, 32'h03);
    check({24'h0, tx_eth}, 32'h14);
    lsm_link_partner_i.send_hf(8'h01, 31'h0, 8'h03, 8'h20);
    rd(8'h20); check(d, 32'h0000_0B60);
    check({24'h0, tx_eth}, 32'h20);
  endtask : test_filter

  task automatic test_range();
    logic [7:0]  hl [4] = '{8'h05, 8'h08, 8'h00, 8'hF0};
    logic [7:0]  el [4] = '{8'h3F, 8'h13, 8'h14, 8'h40};
    logic [31:0] st [4] = '{32'hD7F, 32'hD7F, 32'h854, 32'h854};
    // filters and negotiation off: each in-range sample lands at once
    wr(8'h1C, 32'h0000_0221);
    rd(8'h1C); check(d, 32'h0000_0221);
    check(d2, 32'h0000_0221);
    for (int i = 0; i < 4; i++) begin
      lsm_link_partner_i.send_hf(8'h01, 31'h0, hl[i], el[i]);
      rd(8'h20); check(d, st[i]);
    end
    check({24'h0, tx_hdlc}, 32'h02);
    check({24'h0, tx_eth}, 32'h21);
  endtask : test_range

  task automatic test_scramble();
    lsm_link_partner_i.send_hf(8'h02, 31'h0123_4567, 8'h00, 8'h14);
    rd(8'h18); check(d, 32'h8123_4567);
    lsm_link_partner_i.send_hf(8'h03, 31'h0123_4567, 8'h00, 8'h14);
    rd(8'h18); check(d, 32'h8123_4567);
    lsm_link_partner_i.send_hf(8'h01, 31'h7FFF_FFFF, 8'h00, 8'h14);
    rd(8'h18); check(d, 32'h7FFF_FFFF);
    lsm_link_partner_i.send_word(32'hA5A5_3C3C);
    #1;
    check({31'h0, descr_valid}, 32'h1);
    check(descr_data, 32'hA5A5_3C3C);
    lsm_link_partner_i.send_hf(8'h02, 31'h4000_0001, 8'h00, 8'h14);
    lsm_link_partner_i.send_word(32'hA5A5_3C3C);
    #1;
    check(descr_data, 32'h25A5_3C27);
  endtask : test_scramble

  task automatic test_irq();
    rd(8'h28); check(d, 32'h7);
    check({31'h0, irq}, 32'h0);
    wr(8'h2C, 32'h4);
    repeat (2) @(posedge clock_i);
    #1;
    check({31'h0, irq}, 32'h1);
    wr(8'h28, 32'h4);
    repeat (2) @(posedge clock_i);
    #1;
    check({31'h0, irq}, 32'h0);
    rd(8'h28); check(d, 32'h3);
  endtask : test_irq

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    arst_n_i = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    cycle_cnt = 0;
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    test_reset();
    test_access();
    test_filter();
    test_range();
    test_scramble();
    test_irq();
    stop_test();
  end
endmodule : lsm_regs_tb_top
`default_nettype wire
